//--- logic/clock_dist_pkg.sv
// constants, field layout, reset values and decode functions of the audio clock distribution
// assumes a 25 MHz system clock and word-indexed registers behind an AHB-Lite slave
package clock_dist_pkg;
	localparam logic [7:0] IDX_DIV_CTRL = 8'h07;
	localparam logic [7:0] IDX_SRC_CTRL = 8'h08;
	localparam logic [7:0] IDX_TX_CTRL = 8'h15;
	localparam logic [7:0] IDX_AIF_CTRL = 8'h1c;
	localparam logic [7:0] IDX_RATIO = 8'h20;
	localparam logic [7:0] IDX_STATUS = 8'h21;
	localparam int POS_POST_DIV = 0;
	localparam int POS_FRAC_EN = 2;
	localparam int POS_HALVER = 3;
	localparam int POS_PIN_DIV = 4;
	localparam int POS_PIN_SRC = 3;
	localparam int POS_PIN_EN = 4;
	localparam int POS_MAIN_SRC = 7;
	localparam int POS_TX_SRC = 6;
	localparam int POS_MASTER = 6;
	localparam int POS_RATIO_INT = 22;
	localparam int POS_STAT_POST = 4;
	localparam logic [1:0] RST_POST_DIV = 2'h2;
	localparam logic RST_FRAC_EN = 1'b1;
	localparam logic RST_HALVER = 1'b0;
	localparam logic [1:0] RST_PIN_DIV = 2'h1;
	localparam logic RST_PIN_SRC = 1'b1;
	localparam logic RST_PIN_EN = 1'b1;
	localparam logic RST_MAIN_SRC = 1'b0;
	localparam logic RST_TX_SRC = 1'b1;
	localparam logic RST_MASTER = 1'b0;
	localparam logic [3:0] RST_RATIO_INT = 4'h7;
	localparam logic [21:0] RST_RATIO_FRAC = 22'h36fd21;
	localparam longint CLK_HZ = 25000000;
	localparam longint TOL_PCT = 1;
	localparam longint RATE_192K = 192000;
	localparam longint RATE_176K = 176400;
	localparam longint RATE_96K = 96000;
	localparam longint RATE_88K = 88200;
	localparam longint RATE_48K = 48000;
	localparam longint RATE_44K = 44100;
	localparam longint RATE_32K = 32000;
	localparam logic [10:0] M1_MIN = 11'(CLK_HZ * 100 / (RATE_192K * (100 + TOL_PCT)));
	localparam logic [10:0] M1_MAX = 11'(CLK_HZ * 100 / (RATE_176K * (100 - TOL_PCT)));
	localparam logic [10:0] M2_MIN = 11'(CLK_HZ * 100 / (RATE_96K * (100 + TOL_PCT)));
	localparam logic [10:0] M2_MAX = 11'(CLK_HZ * 100 / (RATE_88K * (100 - TOL_PCT)));
	localparam logic [10:0] M3_MIN = 11'(CLK_HZ * 100 / (RATE_48K * (100 + TOL_PCT)));
	localparam logic [10:0] M3_MAX = 11'(CLK_HZ * 100 / (RATE_44K * (100 - TOL_PCT)));
	localparam logic [10:0] M4_MIN = 11'(CLK_HZ * 100 / (RATE_32K * (100 + TOL_PCT)));
	localparam logic [10:0] M4_MAX = 11'(CLK_HZ * 100 / (RATE_32K * (100 - TOL_PCT)));

	typedef enum logic [4:0] {
		RX_NONE = 5'h01,
		RX_MODE1 = 5'h02,
		RX_MODE2 = 5'h04,
		RX_MODE3 = 5'h08,
		RX_MODE4 = 5'h10
	} rx_mode_t;

	function automatic logic [5:0] postBase(input logic [1:0] sel);
		case (sel)
			2'h0: return 6'h02;
			2'h1: return 6'h04;
			2'h2: return 6'h08;
			default: return 6'h0c;
		endcase
	endfunction

	// pin divider: base scaled by 2^sel / 2, never below 2
	function automatic logic [5:0] divA(input logic [1:0] pd, input logic [1:0] sel);
		logic [7:0] r;
		r = ({2'h0, postBase(pd)} << sel) >> 1;
		return (r < 8'h02) ? 6'h02 : r[5:0];
	endfunction

	function automatic logic [5:0] divB(input logic [1:0] pd, input logic halver);
		return halver ? (postBase(pd) << 1) : postBase(pd);
	endfunction

	function automatic logic [1:0] autoPostDiv(input rx_mode_t m);
		case (m)
			RX_MODE1: return 2'h0;
			RX_MODE2: return 2'h1;
			RX_MODE3: return 2'h2;
			default: return 2'h3;
		endcase
	endfunction

	function automatic rx_mode_t classify(input logic [10:0] p);
		if (p >= M1_MIN && p <= M1_MAX) return RX_MODE1;
		if (p >= M2_MIN && p <= M2_MAX) return RX_MODE2;
		if (p >= M3_MIN && p <= M3_MAX) return RX_MODE3;
		if (p >= M4_MIN && p <= M4_MAX) return RX_MODE4;
		return RX_NONE;
	endfunction
endpackage

//--- logic/clock_mux_if.sv
// two clock sources, a select, and the switched result
// assumes every signal lives in the system clock domain
`timescale 1ns/10ps
interface clock_mux_if;
	logic srcA;
	logic srcB;
	logic sel;
	logic cur;
	logic out;
	modport sw (input srcA, input srcB, input sel, output cur, output out);
	modport user (output srcA, output srcB, output sel, input cur, input out);
endinterface

//--- logic/clock_divider.sv
// even-ratio divider of the f2 tick stream into a clock level
// assumes tick is a one-cycle pulse per rising f2 edge on clk
`timescale 1ns/10ps
module clock_divider #(
	parameter int W = 6
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic tick,
	input wire logic [W-1:0] ratio,
	output logic high_drive_clock_pin
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] half_reg;
	logic [W-1:0] seen_reg;
	logic wrap;

	assign wrap = tick && (cnt_reg >= half_reg - 1'b1);

	// new ratio taken only at the end of a full period
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_reg <= '0;
			high_drive_clock_pin <= 1'b0;
			half_reg <= W'(1);
		end else if (tick) begin
			cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
			if (wrap) begin
				high_drive_clock_pin <= !high_drive_clock_pin;
				if (high_drive_clock_pin)
					half_reg <= ratio >> 1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn || (tick && wrap))
			seen_reg <= '0;
		else if (tick)
			seen_reg <= seen_reg + 1'b1;
	end

	a_half_period: assert property (@(posedge clk) disable iff (!rstn)
		$changed(high_drive_clock_pin) |-> $past(seen_reg) == $past(half_reg) - 1'b1)
		else $error("divider half period wrong");
endmodule

//--- logic/clock_switch.sv
// clock selector that changes source only while both old and new source are low
// assumes both sources are levels sampled on clk
`timescale 1ns/10ps
module clock_switch (
	input wire logic clk,
	input wire logic rstn,
	clock_mux_if.sw m
);
	logic cur_reg;
	logic out_reg;
	logic curNext;

	// no shortened pulse: hand over only when both clocks sit low
	always_comb begin
		curNext = cur_reg;
		if (m.sel != cur_reg && !out_reg && !(m.sel ? m.srcB : m.srcA))
			curNext = m.sel;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cur_reg <= 1'b0;
			out_reg <= 1'b0;
		end else begin
			cur_reg <= curNext;
			out_reg <= curNext ? m.srcB : m.srcA;
		end
	end

	assign m.cur = cur_reg;
	assign m.out = out_reg;

	a_switch_low: assert property (@(posedge clk) disable iff (!rstn)
		$changed(cur_reg) |-> !$past(out_reg) && !out_reg)
		else $error("clock source switched while high");
endmodule

//--- logic/audio_clock_distribution.sv
// audio clock distribution: main clock pin, high-drive clock pin, transmitter reference, receive rate modes
// assumes AHB-Lite single word transfers, f2 as a tick pulse, oscillator and main clock pin as async levels
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/10ps
module audio_clock_distribution (
	input wire logic clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic oscClkIn,
	input wire logic f2Tick,
	input wire logic mainClkIn,
	output logic mainClkOut,
	output logic mainClkOe,
	output logic clkPinOut,
	output logic clkPinOe,
	output logic txRefClk,
	input wire logic rxEnable,
	input wire logic rxFrameTick,
	output logic [3:0] pllIntegerRatio,
	output logic [21:0] pllFractionRatio,
	output logic [1:0] postDividerSel
);
	logic [1:0] postDiv_reg;
	logic fracEn_reg;
	logic halver_reg;
	logic [1:0] pinDiv_reg;
	logic pinSrc_reg;
	logic pinEn_reg;
	logic mainSrc_reg;
	logic transmit_source_sel_reg;
	logic master_reg;
	logic [3:0] ratioInt_reg;
	logic [21:0] ratioFrac_reg;
	logic wrPend_reg;
	logic [5:0] wrIdx_reg;
	logic oscSync1_reg;
	logic oscSync2_reg;
	logic mainSync1_reg;
	logic mainSync2_reg;
	logic [10:0] periodCnt_reg;
	logic [10:0] lastPeriod_reg;
	logic [21:0] trackFrac_reg;
	clock_dist_pkg::rx_mode_t rxMode_reg;
	logic addrAccept;
	logic ratioWrite;
	logic [10:0] period;
	logic rxValid;
	logic divAClk;
	logic divBClk;
	logic pinLevel;

	clock_mux_if mMain();
	clock_mux_if mPin();
	clock_mux_if mTx();
	clock_mux_if mLvl();

	// bus slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addrAccept = hsel && hready && htrans[1];

	function automatic logic [31:0] readReg(input logic [5:0] idx);
		logic [31:0] r;
		r = '0;
		case ({2'h0, idx})
			clock_dist_pkg::IDX_DIV_CTRL: begin
				r[clock_dist_pkg::POS_PIN_DIV +: 2] = pinDiv_reg;
				r[clock_dist_pkg::POS_HALVER] = halver_reg;
				r[clock_dist_pkg::POS_FRAC_EN] = fracEn_reg;
				r[clock_dist_pkg::POS_POST_DIV +: 2] = postDividerSel;
			end
			clock_dist_pkg::IDX_SRC_CTRL: begin
				r[clock_dist_pkg::POS_MAIN_SRC] = mainSrc_reg;
				r[clock_dist_pkg::POS_PIN_EN] = pinEn_reg;
				r[clock_dist_pkg::POS_PIN_SRC] = pinSrc_reg;
			end
			clock_dist_pkg::IDX_TX_CTRL: r[clock_dist_pkg::POS_TX_SRC] = transmit_source_sel_reg;
			clock_dist_pkg::IDX_AIF_CTRL: r[clock_dist_pkg::POS_MASTER] = master_reg;
			clock_dist_pkg::IDX_RATIO: r = {6'h00, pllIntegerRatio, pllFractionRatio};
			clock_dist_pkg::IDX_STATUS: begin
				r[4:0] = rxMode_reg;
				r[clock_dist_pkg::POS_STAT_POST + 4 +: 2] = postDividerSel;
			end
			default: r = '0;
		endcase
		return r;
	endfunction

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wrPend_reg <= 1'b0;
			wrIdx_reg <= '0;
			hrdata <= '0;
		end else begin
			wrPend_reg <= addrAccept && hwrite;
			if (addrAccept)
				wrIdx_reg <= haddr[7:2];
			if (addrAccept && !hwrite)
				hrdata <= readReg(haddr[7:2]);
		end
	end

	assign ratioWrite = wrPend_reg && ({2'h0, wrIdx_reg} == clock_dist_pkg::IDX_RATIO);

	// control registers, written in the data phase
	always_ff @(posedge clk) begin
		if (!rstn) begin
			postDiv_reg <= clock_dist_pkg::RST_POST_DIV;
			fracEn_reg <= clock_dist_pkg::RST_FRAC_EN;
			halver_reg <= clock_dist_pkg::RST_HALVER;
			pinDiv_reg <= clock_dist_pkg::RST_PIN_DIV;
			pinSrc_reg <= clock_dist_pkg::RST_PIN_SRC;
			pinEn_reg <= clock_dist_pkg::RST_PIN_EN;
			mainSrc_reg <= clock_dist_pkg::RST_MAIN_SRC;
			transmit_source_sel_reg <= clock_dist_pkg::RST_TX_SRC;
			master_reg <= clock_dist_pkg::RST_MASTER;
			ratioInt_reg <= clock_dist_pkg::RST_RATIO_INT;
			ratioFrac_reg <= clock_dist_pkg::RST_RATIO_FRAC;
		end else if (wrPend_reg) begin
			case ({2'h0, wrIdx_reg})
				clock_dist_pkg::IDX_DIV_CTRL: begin
					pinDiv_reg <= hwdata[clock_dist_pkg::POS_PIN_DIV +: 2];
					halver_reg <= hwdata[clock_dist_pkg::POS_HALVER];
					fracEn_reg <= hwdata[clock_dist_pkg::POS_FRAC_EN];
					postDiv_reg <= hwdata[clock_dist_pkg::POS_POST_DIV +: 2];
				end
				clock_dist_pkg::IDX_SRC_CTRL: begin
					mainSrc_reg <= hwdata[clock_dist_pkg::POS_MAIN_SRC];
					pinEn_reg <= hwdata[clock_dist_pkg::POS_PIN_EN];
					pinSrc_reg <= hwdata[clock_dist_pkg::POS_PIN_SRC];
				end
				clock_dist_pkg::IDX_TX_CTRL: transmit_source_sel_reg <= hwdata[clock_dist_pkg::POS_TX_SRC];
				clock_dist_pkg::IDX_AIF_CTRL: master_reg <= hwdata[clock_dist_pkg::POS_MASTER];
				clock_dist_pkg::IDX_RATIO: begin
					ratioInt_reg <= hwdata[clock_dist_pkg::POS_RATIO_INT +: 4];
					ratioFrac_reg <= hwdata[21:0];
				end
				default: ;
			endcase
		end
	end

	// pin-level clocks enter through two flops
	always_ff @(posedge clk) begin
		if (!rstn) begin
			oscSync1_reg <= 1'b0;
			oscSync2_reg <= 1'b0;
			mainSync1_reg <= 1'b0;
			mainSync2_reg <= 1'b0;
		end else begin
			oscSync1_reg <= oscClkIn;
			oscSync2_reg <= oscSync1_reg;
			mainSync1_reg <= mainClkIn;
			mainSync2_reg <= mainSync1_reg;
		end
	end

	// frame period measurement and rate mode
	assign period = periodCnt_reg + 1'b1;
	assign rxValid = rxEnable && (rxMode_reg != clock_dist_pkg::RX_NONE);

	always_ff @(posedge clk) begin
		if (!rstn || !rxEnable) begin
			periodCnt_reg <= '0;
			lastPeriod_reg <= '0;
			rxMode_reg <= clock_dist_pkg::RX_NONE;
		end else if (rxFrameTick) begin
			periodCnt_reg <= '0;
			lastPeriod_reg <= period;
			rxMode_reg <= clock_dist_pkg::classify(period);
		end else if (periodCnt_reg != 11'h7ff) begin
			periodCnt_reg <= periodCnt_reg + 1'b1;
		end
	end

	// fraction tracking: longer frames pull f2 down, shorter push it up
	always_ff @(posedge clk) begin
		if (!rstn || !rxEnable || ratioWrite)
			trackFrac_reg <= ratioWrite ? hwdata[21:0] : ratioFrac_reg;
		else if (rxFrameTick && rxValid && fracEn_reg) begin
			if (period > lastPeriod_reg)
				trackFrac_reg <= trackFrac_reg - 1'b1;
			else if (period < lastPeriod_reg)
				trackFrac_reg <= trackFrac_reg + 1'b1;
		end
	end

	assign pllIntegerRatio = ratioInt_reg;
	assign pllFractionRatio = rxEnable ? trackFrac_reg : ratioFrac_reg;
	assign postDividerSel = rxValid ? clock_dist_pkg::autoPostDiv(rxMode_reg) : postDiv_reg;

	// receive mode post divider makes a = 512..64 fs (256..64 fs in mode 1, where divA is clamped to at least 2), b = 256/128 fs
	clock_divider #(.W(6)) divA (
		.clk(clk),
		.rstn(rstn),
		.tick(f2Tick),
		.ratio(clock_dist_pkg::divA(postDividerSel, pinDiv_reg)),
		.high_drive_clock_pin(divAClk)
	);

	clock_divider #(.W(6)) divB (
		.clk(clk),
		.rstn(rstn),
		.tick(f2Tick),
		.ratio(clock_dist_pkg::divB(postDividerSel, halver_reg)),
		.high_drive_clock_pin(divBClk)
	);

	assign mMain.srcA = divBClk;
	assign mMain.srcB = oscSync2_reg;
	assign mMain.sel = mainSrc_reg;
	clock_switch swMain (.clk(clk), .rstn(rstn), .m(mMain.sw));

	assign mPin.srcA = divAClk;
	assign mPin.srcB = oscSync2_reg;
	assign mPin.sel = pinSrc_reg;
	clock_switch swPin (.clk(clk), .rstn(rstn), .m(mPin.sw));

	assign mainClkOut = mMain.out;
	assign mainClkOe = master_reg;
	assign clkPinOut = mPin.out;
	assign clkPinOe = pinEn_reg;

	// level seen at the main clock pin, whichever way it is driven
	// a direction flip hands over like a source change, so no short pulse reaches the transmitter
	assign mLvl.srcA = mainSync2_reg;
	assign mLvl.srcB = mMain.out;
	assign mLvl.sel = master_reg;
	clock_switch swLvl (.clk(clk), .rstn(rstn), .m(mLvl.sw));
	assign pinLevel = mLvl.out;
	assign mTx.srcA = divBClk;
	assign mTx.srcB = pinLevel;
	assign mTx.sel = transmit_source_sel_reg;
	clock_switch swTx (.clk(clk), .rstn(rstn), .m(mTx.sw));
	assign txRefClk = mTx.out;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence wrAif;
		wrPend_reg && ({2'h0, wrIdx_reg} == clock_dist_pkg::IDX_AIF_CTRL);
	endsequence
	sequence wrSrc;
		wrPend_reg && ({2'h0, wrIdx_reg} == clock_dist_pkg::IDX_SRC_CTRL);
	endsequence
	sequence oscSettled;
		mMain.cur && $past(mMain.cur);
	endsequence

	a_pin_direction: assert property (wrAif ##0 hwdata[clock_dist_pkg::POS_MASTER] |=> mainClkOe [*2])
		else $error("main clock pin not driven after master select");
	a_osc_passthru: assert property (oscSettled |-> mainClkOut == $past(oscSync2_reg))
		else $error("main clock does not follow oscillator");
	a_main_divb: assert property (!mMain.cur && !$past(mMain.cur) |-> mainClkOut == $past(divBClk))
		else $error("main clock does not follow divided clock b");
	a_pin_diva: assert property (!mPin.cur && !$past(mPin.cur) |-> clkPinOut == $past(divAClk))
		else $error("clock pin does not follow divided clock a");
	a_pin_disable: assert property (wrSrc ##0 !hwdata[clock_dist_pkg::POS_PIN_EN] |=> !clkPinOe)
		else $error("clock pin still enabled after disable");
	a_tx_pin_ref: assert property (mTx.cur && $past(mTx.cur) |-> txRefClk == $past(pinLevel))
		else $error("transmitter reference not from main clock pin");
	a_mode_class: assert property (rxEnable && rxFrameTick && period >= clock_dist_pkg::M3_MIN
		&& period <= clock_dist_pkg::M3_MAX |=> rxMode_reg == clock_dist_pkg::RX_MODE3)
		else $error("48 kHz class frame not detected as mode 3");
	a_auto_postdiv: assert property (rxEnable && rxMode_reg == clock_dist_pkg::RX_MODE1
		|-> postDividerSel == 2'h0)
		else $error("post divider not forced in mode 1");
	a_track_down: assert property (rxFrameTick && rxValid && fracEn_reg && !ratioWrite
		&& period > lastPeriod_reg |=> pllFractionRatio == $past(trackFrac_reg) - 1'b1)
		else $error("fraction not lowered on longer frame");
endmodule

//--- bench/audio_far_side.sv
// far-side model: oscillator, f2 tick stream, external main clock and received frame ticks
// assumes clk is the 25 MHz system clock; framePeriod is counted in clk cycles
`timescale 1ns/10ps
module audio_far_side #(
	parameter int OSC_HALF_NS = 200,
	parameter int EXT_HALF_NS = 240
) (
	input wire logic clk,
	input wire logic [11:0] framePeriod,
	input wire logic mainClkOe,
	input wire logic mainClkOut,
	output logic oscClkIn,
	output logic f2Tick,
	output logic mainClkIn,
	output logic rxFrameTick
);
	logic extLvl = 1'b0;
	logic [11:0] frameCnt = 12'h000;
	initial f2Tick = 1'b0;
	initial rxFrameTick = 1'b0;
	initial begin
		oscClkIn = 1'b0;
		#7;
		forever #OSC_HALF_NS oscClkIn = ~oscClkIn;
	end
	// applied main clock of 12 cycles, a legal fs multiple for the transmitter
	initial forever #EXT_HALF_NS extLvl = ~extLvl;
	// the device owns the pin in master mode, the far side otherwise
	assign mainClkIn = mainClkOe ? mainClkOut : extLvl;
	always @(posedge clk) begin
		f2Tick <= ~f2Tick;
		frameCnt <= (frameCnt >= framePeriod - 12'h001) ? 12'h000 : frameCnt + 12'h001;
		rxFrameTick <= (frameCnt >= framePeriod - 12'h001);
	end
endmodule

//--- bench/tb.sv
// self-checking bench for the audio clock distribution
// assumes the far-side model supplies clocks and frames; registers reached over AHB-Lite
`timescale 1ns/10ps
module tb;
	typedef struct packed {logic [7:0] div; logic [7:0] src; logic [7:0] pinPer; logic [7:0] mainPer;
		logic [7:0] txPer;} clk_row_t;
	typedef struct packed {logic [7:0] addr; logic [31:0] data;} reg_row_t;
	typedef struct packed {logic [11:0] period; logic [4:0] mode; logic [1:0] post;} rx_row_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic rxEnable = 1'b0;
	logic [11:0] framePeriod = 12'h200;
	logic hreadyout, hresp, oscClkIn, f2Tick, mainClkIn, mainClkOut, mainClkOe, clkPinOut, clkPinOe;
	logic txRefClk, rxFrameTick;
	logic [31:0] hrdata;
	logic [3:0] pllIntegerRatio;
	logic [21:0] pllFractionRatio;
	logic [1:0] postDividerSel;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [2:0] prevLvl = 3'h0;
	logic [2:0] seen = 3'h0;
	int runLen [3];
	clk_row_t rows [7] = '{'{8'h04, 8'h10, 8'h04, 8'h04, 8'h04}, '{8'h1d, 8'h10, 8'h08, 8'h10, 8'h10},
		'{8'h26, 8'h10, 8'h20, 8'h10, 8'h10}, '{8'h3f, 8'h10, 8'h60, 8'h30, 8'h30},
		'{8'h34, 8'h10, 8'h10, 8'h04, 8'h04}, '{8'h0f, 8'h10, 8'h0c, 8'h30, 8'h30},
		'{8'h3f, 8'h98, 8'h0a, 8'h0a, 8'h30}};
	reg_row_t regs [7] = '{'{8'h1c, 32'h16}, '{8'h20, 32'h18}, '{8'h54, 32'h40}, '{8'h70, 32'h0},
		'{8'h80, 32'h01f6fd21}, '{8'h84, 32'h201}, '{8'h40, 32'h0}};
	rx_row_t rxRows [7] = '{'{12'h08f, 5'h02, 2'h0}, '{12'h090, 5'h01, 2'h1}, '{12'h10e, 5'h04, 2'h1},
		'{12'h21c, 5'h08, 2'h2}, '{12'h315, 5'h10, 2'h3}, '{12'h316, 5'h01, 2'h1}, '{12'h080, 5'h02, 2'h0}};

	audio_clock_distribution dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .oscClkIn(oscClkIn), .f2Tick(f2Tick), .mainClkIn(mainClkIn),
		.mainClkOut(mainClkOut), .mainClkOe(mainClkOe), .clkPinOut(clkPinOut), .clkPinOe(clkPinOe),
		.txRefClk(txRefClk), .rxEnable(rxEnable), .rxFrameTick(rxFrameTick),
		.pllIntegerRatio(pllIntegerRatio), .pllFractionRatio(pllFractionRatio), .postDividerSel(postDividerSel));
	audio_far_side far (.clk(clk), .framePeriod(framePeriod), .mainClkOe(mainClkOe), .mainClkOut(mainClkOut),
		.oscClkIn(oscClkIn), .f2Tick(f2Tick), .mainClkIn(mainClkIn), .rxFrameTick(rxFrameTick));

	always #20 clk = ~clk;

	task finish_test();
		$display("mismatches %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			$display("[ERR] %0t timeout", $time);
			finish_test();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
		end
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: return clkPinOut;
			1: return mainClkOut;
			default: return txRefClk;
		endcase
	endfunction

	// no level of a clock output may last a single cycle once it has started toggling
	always @(negedge clk) begin
		for (int i = 0; i < 3; i++) begin
			if (!rstn) begin
				seen[i] = 1'b0;
				runLen[i] = 0;
			end else if (pick(i) !== prevLvl[i]) begin
				if (seen[i]) check({31'h0, runLen[i] >= 2}, 32'h1, "short clock pulse");
				seen[i] = 1'b1;
				runLen[i] = 1;
				prevLvl[i] = pick(i);
			end else
				runLen[i]++;
		end
	end

	task automatic waitRdy();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) check(32'h0, 32'h1, "bus hang");
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hsize <= 3'h2;
		waitRdy();
		htrans <= 2'h0;
		hwdata <= wd;
		waitRdy();
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
		@(negedge clk);
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		check(x, exp, $sformatf("read %h", a));
	endtask

	// period in clk cycles from one rising level to the next
	task automatic measure(input int s, output int per);
		int n;
		per = 0;
		for (int ph = 0; ph < 4; ph++) begin
			n = 0;
			while (pick(s) !== ph[0] && n < 400) begin
				@(negedge clk);
				n++;
			end
			if (ph >= 2) per += n;
		end
	endtask

	task automatic waitFrames(input int cnt);
		int k;
		repeat (cnt) begin
			k = 0;
			while (rxFrameTick !== 1'b1 && k < 2000) begin
				@(negedge clk);
				k++;
			end
			if (k >= 2000) check(32'h0, 32'h1, "no frame");
			@(negedge clk);
		end
	endtask

	initial begin
		int per;
		logic [7:0] exp;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		wr(8'h70, 32'h40);
		wr(8'h54, 32'h0);
		check(mainClkOe, 1'b1, "main pin master");
		for (int i = 0; i < 7; i++) begin
			wr(8'h1c, {24'h0, rows[i].div});
			wr(8'h20, {24'h0, rows[i].src});
			for (int s = 0; s < 3; s++) begin
				exp = (s == 0) ? rows[i].pinPer : (s == 1) ? rows[i].mainPer : rows[i].txPer;
				measure(s, per);
				measure(s, per);
				check(32'(per), {24'h0, exp}, $sformatf("row %0d sig %0d", i, s));
			end
		end
		wr(8'h54, 32'h40);
		measure(2, per);
		measure(2, per);
		check(32'(per), 32'h0a, "tx ref master pin");
		wr(8'h70, 32'h0);
		check(mainClkOe, 1'b0, "main pin slave");
		measure(2, per);
		measure(2, per);
		check(32'(per), 32'h0c, "tx ref applied pin");
		wr(8'h20, 32'h08);
		check(clkPinOe, 1'b0, "pin disabled");
		wr(8'h40, 32'hffffffff);
		wr(8'h84, 32'h0);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		check({hresp, mainClkOe, clkPinOe, postDividerSel, pllIntegerRatio}, 32'h67, "reset ports");
		check(pllFractionRatio, 32'h36fd21, "reset fraction");
		for (int i = 0; i < 7; i++)
			rdChk(regs[i].addr, regs[i].data);
		wr(8'h1c, 32'h15);
		wr(8'h80, 32'h01f6fd21);
		@(posedge clk);
		rxEnable <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			@(posedge clk);
			framePeriod <= rxRows[i].period;
			waitFrames(3);
			check(postDividerSel, rxRows[i].post, "auto post div");
			rdChk(8'h84, {22'h0, rxRows[i].post, 3'h0, rxRows[i].mode});
		end
		// into mode 1 at the highest rate: software loads the faster f2 ratios
		@(posedge clk);
		framePeriod <= 12'h08c;
		waitFrames(2);
		wr(8'h80, 32'h020c49ba);
		check({pllIntegerRatio, 6'h0, pllFractionRatio}, 32'h800c49ba, "mode 1 ratios");
		@(posedge clk);
		framePeriod <= 12'h212;
		waitFrames(2);
		wr(8'h80, 32'h01f6fd21);
		for (int k = 0; k < 5; k++) begin
			@(posedge clk);
			framePeriod <= 12'h213 + 12'(k);
			waitFrames(1);
		end
		waitFrames(1);
		check({31'h0, pllFractionRatio < 22'h36fd21 && pllFractionRatio > 22'h36fd10}, 32'h1, "tracking");
		@(posedge clk);
		rxEnable <= 1'b0;
		repeat (3) @(negedge clk);
		check(pllFractionRatio, 32'h36fd21, "fraction reload");
		check(postDividerSel, 2'h1, "register post div");
		finish_test();
	end
endmodule
